/* File: bench/phm_board.sv */
// board side of port h: resolves each pin from port drive and board level
// assumes one driver per pin; a short lets the board win over the port
`timescale 1ns/1ns
module phm_board (
  // port side
  input  wire logic [7:0] port_out_i,
  input  wire logic [7:0] port_oe_i,
  // board side
  input  wire logic [7:0] board_level_i,
  input  wire logic [7:0] short_mask_i,
  output logic      [7:0] pin_level_o
);
  // driven pins follow the port, shorted or released pins take the board level
  always_comb
  begin
    pin_level_o = (port_out_i & port_oe_i & ~short_mask_i)
                | (board_level_i & ~(port_oe_i & ~short_mask_i));
  end
endmodule

/* File: bench/tb_top.sv */
// testbench for the port h pin mux: axi4-lite traffic and pin checks
// assumes the board model resolves the pin levels seen by the block
`timescale 1ns/1ns
module tb_top;
  import phm_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic        clock    = 1'b0;   // 50 mhz bus clock
  logic        rst_n    = 1'b0;   // active low reset
  logic        awvalid  = 1'b0;   // write address channel
  logic [11:0] awaddr   = 12'h000;
  logic        wvalid   = 1'b0;   // write data channel
  logic [31:0] wdata    = 32'h0;
  logic        bready   = 1'b0;   // write response ready
  logic        arvalid  = 1'b0;   // read address channel
  logic [11:0] araddr   = 12'h000;
  logic        rready   = 1'b0;   // read data ready
  logic        txd      = 1'b0;   // serial transmit into the mux
  logic [3:0]  spi      = 4'h0;   // mosi, mosi_oe, miso_out, miso_oe
  logic [7:0]  board    = 8'h96;  // board level on released pins
  logic [7:0]  short_m  = 8'h00;  // pins the board overrides
  wire         awready, wready, bvalid, arready, rvalid, rxd, miso;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  pin_in, pin_out, pin_oe;
  int          bad_count = 0;     // mismatches
  int          checks    = 0;     // comparisons
  logic [31:0] rd;                // last read data
  logic [1:0]  rs;                // last response
  // ************************************************************
  // design and board
  // ************************************************************
  phm_port_h_pin_io_mux DUT (.clock_i(clock), .rst_n_i(rst_n),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'h1), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .pin_i(pin_in), .pin_o(pin_out),
    .pin_oe_o(pin_oe), .serial_txd_i(txd), .serial_rxd_o(rxd), .spi_mosi_i(spi[3]),
    .spi_mosi_oe_i(spi[2]), .spi_miso_o(miso), .spi_miso_oe_i(spi[0]),
    .spi_miso_out_i(spi[1]));
  phm_board board_model (.port_out_i(pin_out), .port_oe_i(pin_oe),
    .board_level_i(board), .short_mask_i(short_m), .pin_level_o(pin_in));
  // ************************************************************
  // clock, compare and closing
  // ************************************************************
  initial
  begin
    forever #10 clock = ~clock;
  end
  // one comparison, counted, reported at once on mismatch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ************************************************************
  // bus tasks
  // ************************************************************
  // write: address and data offered together, held until each is taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (aw_ok && w_ok && bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
      if (!aw_ok && awready) awvalid <= 1'b0;
      if (!aw_ok && awready) aw_ok = 1;
      if (!w_ok && wready) wvalid <= 1'b0;
      if (!w_ok && wready) w_ok = 1;
    end
    // one idle edge, so a following call never re-drives bready in this step
    @(posedge clock);
  endtask
  // read: address held until taken, rready held until the data arrives
  task automatic axi_read(input logic [11:0] a);
    bit ar_ok;
    ar_ok = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (ar_ok && rvalid)
      begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
      if (!ar_ok && arready) arvalid <= 1'b0;
      if (!ar_ok && arready) ar_ok = 1;
    end
    // one idle edge, so a following call never re-drives rready in this step
    @(posedge clock);
  endtask
  // pin levels need two synchroniser clocks; four leaves margin
  task automatic settle;
    repeat (4) @(posedge clock);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  // after reset all pins are inputs, so data reads the pins
  task automatic t_reset_state;
    chk("pin_oe", 32'h0, pin_oe);
    axi_read(PORT_H_DATA_OFF);
    chk("data", 32'h96, rd);
    axi_read(PORT_H_PIN_INPUT_OFF);
    chk("pin input", 32'h96, rd);
  endtask
  // reserved slot keeps nothing
  task automatic t_reserved;
    axi_write(RESERVED_SLOT_OFF, 32'hff);
    axi_read(RESERVED_SLOT_OFF);
    chk("reserved", 32'h0, rd);
    chk("reserved resp", RESP_OKAY, rs);
  endtask
  // shorted outputs: data shows the register, pin input shows the pins
  task automatic t_short;
    axi_write(PORT_H_DIR_OFF, 32'hff);
    axi_write(PORT_H_DATA_OFF, 32'ha5);
    short_m <= 8'hf0;
    board <= 8'h0f;
    settle();
    axi_write(PORT_H_PIN_INPUT_OFF, 32'hff);
    axi_read(PORT_H_PIN_INPUT_OFF);
    chk("pin input", 32'h05, rd);
    axi_read(PORT_H_DATA_OFF);
    chk("data out", 32'ha5, rd);
    short_m <= 8'h00;
  endtask
  // mixed direction: per bit register or pin, drivers follow direction
  task automatic t_mixed;
    axi_write(PORT_H_DIR_OFF, 32'h0f);
    axi_write(PORT_H_DATA_OFF, 32'h5a);
    board <= 8'h3c;
    settle();
    chk("pin_oe", 32'h0f, pin_oe);
    chk("pin_o low", 32'h0a, pin_out & 8'h0f);
    axi_read(PORT_H_DATA_OFF);
    chk("data mixed", 32'h3a, rd);
  endtask
  // every enable code: spi over serial over gpio on pins 1 and 0
  task automatic t_owner;
    axi_write(PORT_H_DIR_OFF, 32'h03);
    axi_write(PORT_H_DATA_OFF, 32'h02);
    txd <= 1'b0;
    spi <= 4'b1100;
    for (int e = 0; e < 4; e++)
    begin
      board <= (e > 1) ? 8'h01 : 8'h00;
      axi_write(FUNC_ENABLE_OFF, e);
      settle();
      chk("oe 1:0", (e == 0) ? 2'b11 : 2'b10, pin_oe[1:0]);
      chk("pin 1", (e == 1) ? 1'b0 : 1'b1, pin_out[1]);
      chk("rxd", (e == 1) ? 1'b0 : 1'b1, rxd);
      chk("miso", (e > 1) ? 1'b1 : 1'b0, miso);
    end
    // spi enables decide the drivers: mosi released, miso driven high
    spi <= 4'b0011;
    axi_write(FUNC_ENABLE_OFF, 32'h2);
    settle();
    chk("spi oe", 32'h1, pin_oe[1:0]);
    chk("spi pins", 32'h1, pin_out[1:0]);
    axi_write(FUNC_ENABLE_OFF, 32'h0);
  endtask
  // reset in mid-run returns direction and enables to their reset values
  task automatic t_mid_reset;
    axi_write(PORT_H_DIR_OFF, 32'hff);
    axi_write(FUNC_ENABLE_OFF, 32'h2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk("oe in reset", 32'h0, pin_oe);
    rst_n <= 1'b1;
    settle();
    axi_read(PORT_H_DIR_OFF);
    chk("dir after reset", {24'h0, DIR_RESET}, rd);
    chk("miso after reset", 32'h0, miso);
  endtask
  // unmapped place answers with an error and zero data
  task automatic t_unmapped;
    axi_write(12'h020, 32'hff);
    chk("unmapped write", RESP_SLVERR, rs);
    axi_read(12'h020);
    chk("unmapped read", RESP_SLVERR, rs);
    chk("unmapped data", 32'h0, rd);
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    settle();
    t_reset_state();
    t_reserved();
    t_short();
    t_mixed();
    t_owner();
    t_mid_reset();
    t_unmapped();
    report_and_stop();
  end
  // the run needs well under 1000 cycles; 5000 means a hang
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule

/* File: rtl/phm_pkg.sv */
// package for the port h pin mux block: register map, field layout, reset values
// assumes a 32-bit axi4-lite slave with one aligned word per register
package phm_pkg;
  // ************************************************************
  // register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [11:0] PORT_H_DATA_OFF      = 12'h000; // data register
  localparam logic [11:0] PORT_H_DIR_OFF       = 12'h004; // direction bits
  localparam logic [11:0] PORT_H_PIN_INPUT_OFF = 12'h008; // read-only pin levels
  localparam logic [11:0] RESERVED_SLOT_OFF    = 12'h00c; // always reads zero
  localparam logic [11:0] FUNC_ENABLE_OFF      = 12'h010; // alternate function enables
  // ************************************************************
  // widths, fields and reset values
  // ************************************************************
  localparam int          PORT_W          = 8;     // port width
  localparam int          ADDR_W          = 12;    // decoded address width
  localparam int          PIN_MISO_RXD    = 0;     // pin 0: receive / master-in
  localparam int          PIN_MOSI_TXD    = 1;     // pin 1: transmit / master-out
  localparam int          EN_SERIAL_BIT   = 0;     // serial channel six enable
  localparam int          EN_SPI_BIT      = 1;     // routed spi one enable
  localparam logic [7:0]  DATA_RESET      = 8'h00; // data register reset
  localparam logic [7:0]  DIR_RESET       = 8'h00; // all pins input at reset
  localparam logic [1:0]  ENABLE_RESET    = 2'h0;  // alternate functions off
  localparam logic [7:0]  RESERVED_VALUE  = 8'h00; // reserved slot read value
  localparam logic [1:0]  RESP_OKAY       = 2'h0;  // axi okay
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;  // axi slave error
  // pin owner selection
  typedef enum logic [1:0] {PHM_OWN_GPIO, PHM_OWN_SERIAL, PHM_OWN_SPI} phm_owner_e;
endpackage

/* File: rtl/phm_port_h_pin_io_mux.sv */
// port h lower pin multiplexer with data, direction and pin-input registers
// assumes an axi4-lite master on clock_i, async board pins, and peripherals
// serial channel six and routed spi one on the same clock
//
// How it works
// - reserved slot reads zero, ignores writes
// - pin 1 shares serial transmit and spi master-out
// - pin 0 shares serial receive and spi master-in
// - enabled spi overrides serial and gpio
// - serial overrides gpio; neither means gpio
// - data read: register if output, else pin
// - input register always returns buffered pin levels
// - input register readable anytime, writes discarded
`timescale 1ns/1ns
module phm_port_h_pin_io_mux
  import phm_pkg::*;
(
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  // axi4-lite write address
  input  wire logic                        s_axi_awvalid_i,
  output logic                             s_axi_awready_o,
  input  wire logic [phm_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
  // axi4-lite write data
  input  wire logic                        s_axi_wvalid_i,
  output logic                             s_axi_wready_o,
  input  wire logic [31:0]                 s_axi_wdata_i,
  input  wire logic [3:0]                  s_axi_wstrb_i,
  // axi4-lite write response
  output logic                             s_axi_bvalid_o,
  input  wire logic                        s_axi_bready_i,
  output logic [1:0]                       s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic                        s_axi_arvalid_i,
  output logic                             s_axi_arready_o,
  input  wire logic [phm_pkg::ADDR_W-1:0]  s_axi_araddr_i,
  // axi4-lite read data
  output logic                             s_axi_rvalid_o,
  input  wire logic                        s_axi_rready_i,
  output logic [31:0]                      s_axi_rdata_o,
  output logic [1:0]                       s_axi_rresp_o,
  // port pins
  input  wire logic [phm_pkg::PORT_W-1:0]  pin_i,
  output logic      [phm_pkg::PORT_W-1:0]  pin_o,
  output logic      [phm_pkg::PORT_W-1:0]  pin_oe_o,
  // serial channel six
  input  wire logic                        serial_txd_i,
  output logic                             serial_rxd_o,
  // routed spi one
  input  wire logic                        spi_mosi_i,
  input  wire logic                        spi_mosi_oe_i,
  output logic                             spi_miso_o,
  input  wire logic                        spi_miso_oe_i,
  input  wire logic                        spi_miso_out_i
);
  import phm_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [PORT_W-1:0] port_h_data_bits;      // stored data
  logic [PORT_W-1:0] port_h_direction_bits; // 1 = output
  logic [1:0]        func_enable;           // alternate enables
  logic [PORT_W-1:0] port_h_pin_levels;     // synchronised pins
  logic              aw_held;               // write address captured
  logic              w_held;                // write data captured
  logic [ADDR_W-1:0] aw_addr;               // captured write address
  logic [31:0]       w_data;                // captured write data
  logic [3:0]        w_strb;                // captured byte enables
  logic              do_write;              // both halves present
  logic              write_hit;             // write address mapped
  logic              read_hit;              // read address mapped
  logic [31:0]       next_rdata;            // read mux output
  phm_owner_e        owner;                 // shared pin owner

  // decode of a mapped address, used for read and write
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == PORT_H_DATA_OFF) || (a == PORT_H_DIR_OFF) ||
                  (a == PORT_H_PIN_INPUT_OFF) || (a == RESERVED_SLOT_OFF) ||
                  (a == FUNC_ENABLE_OFF);
  endfunction

  // ************************************************************
  // pin input synchroniser
  // ************************************************************
  phm_sync u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (pin_i),
    .sync_o  (port_h_pin_levels)
  );

  // ************************************************************
  // write channel
  // ************************************************************
  // address and data accepted independently, one write in flight
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign do_write        = aw_held && w_held && !s_axi_bvalid_o;
  assign write_hit       = addr_mapped(aw_addr);

  // capture write address and data
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr_i[ADDR_W-1:2], 2'b00};
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, slave error for unmapped addresses
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_i)
    begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ************************************************************
  // register updates
  // ************************************************************
  // only byte lane 0 carries the 8-bit registers; pin input and
  // reserved slot have no storage so writes fall through
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_h_data_bits      <= DATA_RESET;
      port_h_direction_bits <= DIR_RESET;
      func_enable           <= ENABLE_RESET;
    end
    else if (do_write && w_strb[0])
    begin
      unique case (aw_addr)
        PORT_H_DATA_OFF:  port_h_data_bits      <= w_data[7:0];
        PORT_H_DIR_OFF:   port_h_direction_bits <= w_data[7:0];
        FUNC_ENABLE_OFF:  func_enable           <= w_data[1:0];
        default:          ;
      endcase
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign read_hit        = addr_mapped({s_axi_araddr_i[ADDR_W-1:2], 2'b00});

  // read data mux, upper bits zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case ({s_axi_araddr_i[ADDR_W-1:2], 2'b00})
      // per bit: output reads register, input reads pin
      PORT_H_DATA_OFF:
        next_rdata[7:0] = (port_h_direction_bits & port_h_data_bits) |
                          (~port_h_direction_bits & port_h_pin_levels);
      PORT_H_DIR_OFF:       next_rdata[7:0] = port_h_direction_bits;
      PORT_H_PIN_INPUT_OFF: next_rdata[7:0] = port_h_pin_levels;
      RESERVED_SLOT_OFF:    next_rdata[7:0] = RESERVED_VALUE;
      FUNC_ENABLE_OFF:      next_rdata[1:0] = func_enable;
      default:              next_rdata      = 32'h0000_0000;
    endcase
  end

  // read data register, one cycle after acceptance
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= next_rdata;
      s_axi_rresp_o  <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ************************************************************
  // pin ownership
  // ************************************************************
  // spi has highest precedence, then serial, then gpio
  always_comb
  begin
    if (func_enable[EN_SPI_BIT])
      owner = PHM_OWN_SPI;
    else if (func_enable[EN_SERIAL_BIT])
      owner = PHM_OWN_SERIAL;
    else
      owner = PHM_OWN_GPIO;
  end

  // pin drivers; upper pins are plain gpio
  always_comb
  begin
    pin_o    = port_h_data_bits;
    pin_oe_o = port_h_direction_bits;
    unique case (owner)
      PHM_OWN_SPI:
      begin
        pin_o[PIN_MOSI_TXD]    = spi_mosi_i;
        pin_oe_o[PIN_MOSI_TXD] = spi_mosi_oe_i;
        pin_o[PIN_MISO_RXD]    = spi_miso_out_i;
        pin_oe_o[PIN_MISO_RXD] = spi_miso_oe_i;
      end
      PHM_OWN_SERIAL:
      begin
        pin_o[PIN_MOSI_TXD]    = serial_txd_i;
        pin_oe_o[PIN_MOSI_TXD] = 1'b1;
        pin_o[PIN_MISO_RXD]    = 1'b0;
        pin_oe_o[PIN_MISO_RXD] = 1'b0;
      end
      PHM_OWN_GPIO: ;
    endcase
  end

  // receive paths from the synchronised pin 0 level; serial receive idles high, spi master-in idles low when not owner
  assign serial_rxd_o = (owner == PHM_OWN_SERIAL) ? port_h_pin_levels[PIN_MISO_RXD] : 1'b1;
  assign spi_miso_o   = (owner == PHM_OWN_SPI) ? port_h_pin_levels[PIN_MISO_RXD] : 1'b0;

  // ************************************************************
  // assertions
  // ************************************************************
  a_spi_wins_pin1: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    func_enable[EN_SPI_BIT] |-> pin_o[PIN_MOSI_TXD] == spi_mosi_i)
    else $error("spi does not own pin 1");
  a_serial_tx_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (func_enable == 2'b01) |-> pin_o[PIN_MOSI_TXD] == serial_txd_i && pin_oe_o[PIN_MOSI_TXD])
    else $error("serial transmit not on pin 1");
  a_rx_pin_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (func_enable == 2'b01) |-> serial_rxd_o == port_h_pin_levels[PIN_MISO_RXD])
    else $error("serial receive not from pin 0");
  a_gpio_default: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (func_enable == 2'b00) |-> pin_oe_o == port_h_direction_bits)
    else $error("gpio not in control");
  a_gpio_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pin_oe_o[7:2] == port_h_direction_bits[7:2] && pin_o[7:2] == port_h_data_bits[7:2])
    else $error("gpio driver mismatch");
  a_data_readback: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (s_axi_arvalid_i && s_axi_arready_o &&
     {s_axi_araddr_i[ADDR_W-1:2], 2'b00} == PORT_H_DATA_OFF)
    |=> s_axi_rdata_o[7:0] == (($past(port_h_direction_bits) & $past(port_h_data_bits)) |
        (~$past(port_h_direction_bits) & $past(port_h_pin_levels))))
    else $error("data readback wrong");
  a_pin_input_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (s_axi_arvalid_i && s_axi_arready_o &&
     {s_axi_araddr_i[ADDR_W-1:2], 2'b00} == PORT_H_PIN_INPUT_OFF)
    |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h000000, $past(port_h_pin_levels)})
    else $error("pin input read wrong");
  a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (s_axi_arvalid_i && s_axi_arready_o &&
     {s_axi_araddr_i[ADDR_W-1:2], 2'b00} == RESERVED_SLOT_OFF)
    |=> s_axi_rdata_o == 32'h0000_0000)
    else $error("reserved slot not zero");
  a_ro_write_inert: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (do_write && (aw_addr == PORT_H_PIN_INPUT_OFF || aw_addr == RESERVED_SLOT_OFF))
    |=> $stable(port_h_data_bits) && $stable(port_h_direction_bits) &&
        $stable(func_enable))
    else $error("write to read-only slot changed state");
  c_spi_mode: cover property (@(posedge clock_i) func_enable[EN_SPI_BIT]);
  c_serial_mode: cover property (@(posedge clock_i) func_enable == 2'b01);
  c_write_done: cover property (@(posedge clock_i) s_axi_bvalid_o && s_axi_bready_i);
  c_read_done: cover property (@(posedge clock_i) s_axi_rvalid_o && s_axi_rready_i);
endmodule

/* File: rtl/phm_sync.sv */
// two flip-flop synchroniser for the port pin inputs
// assumes pin levels are asynchronous to clock_i
`timescale 1ns/1ns
module phm_sync
  import phm_pkg::*;
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // levels
  input  wire logic [PORT_W-1:0] async_i,
  output logic      [PORT_W-1:0] sync_o
);
  logic [PORT_W-1:0] stage_one; // first stage, read only by second stage

  // ************************************************************
  // two stage capture
  // ************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage_one <= '0;
      sync_o    <= '0;
    end
    else
    begin
      stage_one <= async_i;
      sync_o    <= stage_one;
    end
  end
endmodule
